// *** verilog/ext_irq_controller.sv ***
module ext_irq_controller
  import ext_irq_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write address
  input wire logic [REG_ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // axi4-lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read address
  input wire logic [REG_ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // axi4-lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // external pins
  input wire logic ext_irq0,
  input wire logic [PIN_COUNT-1:0] pin_change_input,
  // cpu interrupt system
  input wire logic global_irq_en,
  input wire logic [SRC_COUNT-1:0] service_ack,
  output logic [SRC_COUNT-1:0] irq_request,
  // summary interrupt
  output logic irq
);

  // ****************************************************************
  // pin sampling
  // ****************************************************************
  pin_event_if #(.WIDTH(SAMPLED_W)) pin_ev ();
  logic [SAMPLED_W-1:0] all_pins;

  // the pin inputs are read whatever the port direction, so driving them as outputs still triggers
  assign all_pins = {ext_irq0, pin_change_input};

  pin_edge_sampler #(
    .WIDTH(SAMPLED_W)
  ) u_sampler (
    .aclk(aclk),
    .aresetn(aresetn),
    .pins(all_pins),
    .events(pin_ev.source)
  );

  // ****************************************************************
  // registers
  // ****************************************************************
  logic [7:0] pc_mask_group0;
  logic [GROUP1_W-1:0] pc_mask_group1;
  logic [GROUP2_W-1:0] pc_mask_group2;
  logic [7:0] irq_enables;
  logic [7:0] irq_flags;
  logic [1:0] sense;
  logic [7:0] event_status;
  logic [7:0] event_mask;
  logic [1:0] level_primed;

  // ****************************************************************
  // axi write channel holders
  // ****************************************************************
  logic aw_full;
  logic w_full;
  logic [REG_ADDR_W-1:0] wr_addr;
  logic [7:0] wr_data;
  logic wr_lane0;
  logic aw_take;
  logic w_take;
  logic do_write;
  logic next_aw_full;
  logic next_w_full;
  logic next_bvalid;
  logic wr_known;

  // address and data may arrive in either order; each is held until both are present
  assign aw_take = s_axi_awvalid & s_axi_awready;
  assign w_take = s_axi_wvalid & s_axi_wready;
  assign do_write = aw_full & w_full & ~s_axi_bvalid;
  assign next_aw_full = do_write ? 1'b0 : (aw_full | aw_take);
  assign next_w_full = do_write ? 1'b0 : (w_full | w_take);
  assign next_bvalid = do_write | (s_axi_bvalid & ~s_axi_bready);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full <= 1'b0;
      w_full <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
    end else begin
      aw_full <= next_aw_full;
      w_full <= next_w_full;
      s_axi_awready <= ~next_aw_full & ~next_bvalid;
      s_axi_wready <= ~next_w_full & ~next_bvalid;
      s_axi_bvalid <= next_bvalid;
    end
  end

  // payload capture, no reset needed beyond defined values
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_addr <= '0;
      wr_data <= 8'h00;
      wr_lane0 <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else begin
      if (aw_take) begin
        wr_addr <= s_axi_awaddr;
      end
      if (w_take) begin
        wr_data <= s_axi_wdata[7:0];
        wr_lane0 <= s_axi_wstrb[0];
      end
      if (do_write) begin
        s_axi_bresp <= wr_known ? RESP_OKAY : RESP_SLVERR;
      end
    end
  end

  // ****************************************************************
  // write decode
  // ****************************************************************
  logic wr_hit_mask0;
  logic wr_hit_mask1;
  logic wr_hit_mask2;
  logic wr_hit_enables;
  logic wr_hit_flags;
  logic wr_hit_sense;
  logic wr_hit_evmask;
  logic wr_hit_status;
  logic wr_go;

  // only byte lane 0 carries data; a write without it changes nothing
  assign wr_go = do_write & wr_lane0;
  assign wr_hit_mask0 = wr_go & (wr_addr == ADDR_PC_MASK_GROUP0);
  assign wr_hit_mask1 = wr_go & (wr_addr == ADDR_PC_MASK_GROUP1);
  assign wr_hit_mask2 = wr_go & (wr_addr == ADDR_PC_MASK_GROUP2);
  assign wr_hit_enables = wr_go & (wr_addr == ADDR_IRQ_ENABLES);
  assign wr_hit_flags = wr_go & (wr_addr == ADDR_IRQ_FLAGS);
  assign wr_hit_sense = wr_go & (wr_addr == ADDR_SENSE);
  assign wr_hit_evmask = wr_go & (wr_addr == ADDR_EVENT_MASK);
  assign wr_hit_status = wr_addr == ADDR_EVENT_STATUS;
  assign wr_known = (wr_addr == ADDR_PC_MASK_GROUP0) | (wr_addr == ADDR_PC_MASK_GROUP1) |
                    (wr_addr == ADDR_PC_MASK_GROUP2) | (wr_addr == ADDR_IRQ_ENABLES) |
                    (wr_addr == ADDR_IRQ_FLAGS) | (wr_addr == ADDR_SENSE) |
                    (wr_addr == ADDR_EVENT_MASK) | wr_hit_status;

  // ****************************************************************
  // trigger detection
  // ****************************************************************
  sense_type sense_mode;
  logic level_mode;
  logic ext0_low;
  logic ext0_edge_hit;
  logic [PIN_COUNT-1:0] pin_changed;
  logic group0_hit;
  logic group1_hit;
  logic group2_hit;

  assign sense_mode = sense_type'(sense);
  assign level_mode = sense_mode == SENSE_LOW;
  // low level needs no edge, only the sampled level; the source must hold it long enough
  assign ext0_low = level_primed[1] & ~pin_ev.level[EXT_IRQ0_SLOT];
  assign ext0_edge_hit = ((sense_mode == SENSE_CHANGE) &
                          (pin_ev.rise[EXT_IRQ0_SLOT] | pin_ev.fall[EXT_IRQ0_SLOT])) |
                         ((sense_mode == SENSE_FALL) & pin_ev.fall[EXT_IRQ0_SLOT]) |
                         ((sense_mode == SENSE_RISE) & pin_ev.rise[EXT_IRQ0_SLOT]);
  assign pin_changed = pin_ev.rise[PIN_COUNT-1:0] | pin_ev.fall[PIN_COUNT-1:0];
  // a pin joins its group only with its own mask bit and the group enable
  assign group0_hit = irq_enables[BIT_GROUP0] &
                      (|(pin_changed[GROUP0_BASE +: GROUP0_W] & pc_mask_group0));
  assign group1_hit = irq_enables[BIT_GROUP1] &
                      (|(pin_changed[GROUP1_BASE +: GROUP1_W] & pc_mask_group1));
  assign group2_hit = irq_enables[BIT_GROUP2] &
                      (|(pin_changed[GROUP2_BASE +: GROUP2_W] & pc_mask_group2));

  // ****************************************************************
  // flag register update
  // ****************************************************************
  logic [7:0] flag_set;
  logic [7:0] flag_ack;
  logic [7:0] flag_w1c;
  logic [7:0] flag_level_clear;
  logic [7:0] next_irq_flags;

  assign flag_set = {1'b0, ext0_edge_hit, group2_hit, group1_hit, group0_hit, 3'h0};
  assign flag_ack = {1'b0, service_ack[SRC_EXT_IRQ0], service_ack[SRC_GROUP2],
                     service_ack[SRC_GROUP1], service_ack[SRC_GROUP0], 3'h0};
  assign flag_w1c = wr_hit_flags ? wr_data : 8'h00;
  assign flag_level_clear = {1'b0, level_mode, 6'h00};
  // a new trigger in the clearing cycle survives: set wins over clear
  assign next_irq_flags = ((irq_flags & ~(flag_ack | flag_w1c | flag_level_clear)) | flag_set) &
                          SOURCE_BITS_MASK;

  // ****************************************************************
  // event status for the summary interrupt
  // ****************************************************************
  logic [7:0] status_set;
  logic status_read_clear;
  logic [7:0] next_event_status;

  // in level mode the low pin keeps re-arming its status bit for as long as it stays low
  assign status_set = {1'b0, ext0_edge_hit | (level_mode & ext0_low), group2_hit, group1_hit, group0_hit, 3'h0};
  assign next_event_status = ((status_read_clear ? 8'h00 : event_status) | status_set) & SOURCE_BITS_MASK;

  // ****************************************************************
  // register storage
  // ****************************************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pc_mask_group0 <= RST_PC_MASK_GROUP0;
      pc_mask_group1 <= RST_PC_MASK_GROUP1;
      pc_mask_group2 <= RST_PC_MASK_GROUP2;
      irq_enables <= RST_IRQ_ENABLES;
      sense <= RST_SENSE;
      event_mask <= RST_EVENT_MASK;
      irq_flags <= RST_IRQ_FLAGS;
      event_status <= RST_EVENT_STATUS;
      level_primed <= 2'h0;
    end else begin
      if (wr_hit_mask0) pc_mask_group0 <= wr_data;
      if (wr_hit_mask1) pc_mask_group1 <= wr_data[GROUP1_W-1:0];
      if (wr_hit_mask2) pc_mask_group2 <= wr_data[GROUP2_W-1:0];
      if (wr_hit_enables) irq_enables <= wr_data & SOURCE_BITS_MASK;
      if (wr_hit_sense) sense <= wr_data[1:0];
      if (wr_hit_evmask) event_mask <= wr_data & SOURCE_BITS_MASK;
      irq_flags <= next_irq_flags;
      event_status <= next_event_status;
      level_primed <= {level_primed[0], 1'b1}; // pin settles after two edges
    end
  end

  // ****************************************************************
  // requests toward the cpu
  // ****************************************************************
  logic [SRC_COUNT-1:0] next_irq_request;
  logic ext0_pending;

  // level mode requests straight from the pin since its flag is held clear
  assign ext0_pending = level_mode ? ext0_low : irq_flags[BIT_EXT_IRQ0];
  assign next_irq_request[SRC_EXT_IRQ0] = global_irq_en & irq_enables[BIT_EXT_IRQ0] & ext0_pending;
  assign next_irq_request[SRC_GROUP0] = global_irq_en & irq_enables[BIT_GROUP0] & irq_flags[BIT_GROUP0];
  assign next_irq_request[SRC_GROUP1] = global_irq_en & irq_enables[BIT_GROUP1] & irq_flags[BIT_GROUP1];
  assign next_irq_request[SRC_GROUP2] = global_irq_en & irq_enables[BIT_GROUP2] & irq_flags[BIT_GROUP2];

  // registered so that no decode glitch reaches the cpu
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_request <= '0;
      irq <= 1'b0;
    end else begin
      irq_request <= next_irq_request;
      irq <= |(next_event_status & event_mask);
    end
  end

  // ****************************************************************
  // axi read channel
  // ****************************************************************
  logic ar_take;
  logic next_rvalid;
  logic [7:0] rd_value;
  logic rd_known;

  assign ar_take = s_axi_arvalid & s_axi_arready;
  assign next_rvalid = ar_take | (s_axi_rvalid & ~s_axi_rready);
  assign status_read_clear = ar_take & (s_axi_araddr == ADDR_EVENT_STATUS);

  // read mux; reserved bits are zero by construction of the stored values
  always_comb begin
    rd_value = 8'h00;
    rd_known = 1'b1;
    if (s_axi_araddr == ADDR_PC_MASK_GROUP0) begin
      rd_value = pc_mask_group0;
    end else if (s_axi_araddr == ADDR_PC_MASK_GROUP1) begin
      rd_value = {4'h0, pc_mask_group1};
    end else if (s_axi_araddr == ADDR_PC_MASK_GROUP2) begin
      rd_value = {2'h0, pc_mask_group2};
    end else if (s_axi_araddr == ADDR_IRQ_ENABLES) begin
      rd_value = irq_enables;
    end else if (s_axi_araddr == ADDR_IRQ_FLAGS) begin
      rd_value = irq_flags & ~flag_level_clear;
    end else if (s_axi_araddr == ADDR_SENSE) begin
      rd_value = {6'h00, sense};
    end else if (s_axi_araddr == ADDR_EVENT_STATUS) begin
      rd_value = event_status;
    end else if (s_axi_araddr == ADDR_EVENT_MASK) begin
      rd_value = event_mask;
    end else begin
      rd_known = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= RESP_OKAY;
    end else begin
      s_axi_arready <= ~next_rvalid;
      s_axi_rvalid <= next_rvalid;
      if (ar_take) begin
        s_axi_rdata <= {24'h000000, rd_value};
        s_axi_rresp <= rd_known ? RESP_OKAY : RESP_SLVERR;
      end
    end
  end

endmodule : ext_irq_controller

// *** verilog/ext_irq_pkg.sv ***
package ext_irq_pkg;

  // ****************************************************************
  // register map: index constants, byte address is four times index
  // ****************************************************************
  localparam int REG_ADDR_W = 12;
  localparam logic [REG_ADDR_W-1:0] IDX_PC_MASK_GROUP0 = 12'h027;
  localparam logic [REG_ADDR_W-1:0] IDX_PC_MASK_GROUP1 = 12'h028;
  localparam logic [REG_ADDR_W-1:0] IDX_IRQ_FLAGS = 12'h03B;
  localparam logic [REG_ADDR_W-1:0] IDX_IRQ_ENABLES = 12'h03C;
  localparam logic [REG_ADDR_W-1:0] IDX_PC_MASK_GROUP2 = 12'h040;
  localparam logic [REG_ADDR_W-1:0] IDX_SENSE = 12'h041;
  localparam logic [REG_ADDR_W-1:0] IDX_EVENT_STATUS = 12'h042;
  localparam logic [REG_ADDR_W-1:0] IDX_EVENT_MASK = 12'h043;
  localparam logic [REG_ADDR_W-1:0] ADDR_PC_MASK_GROUP0 = {IDX_PC_MASK_GROUP0[REG_ADDR_W-3:0], 2'h0};
  localparam logic [REG_ADDR_W-1:0] ADDR_PC_MASK_GROUP1 = {IDX_PC_MASK_GROUP1[REG_ADDR_W-3:0], 2'h0};
  localparam logic [REG_ADDR_W-1:0] ADDR_IRQ_FLAGS = {IDX_IRQ_FLAGS[REG_ADDR_W-3:0], 2'h0};
  localparam logic [REG_ADDR_W-1:0] ADDR_IRQ_ENABLES = {IDX_IRQ_ENABLES[REG_ADDR_W-3:0], 2'h0};
  localparam logic [REG_ADDR_W-1:0] ADDR_PC_MASK_GROUP2 = {IDX_PC_MASK_GROUP2[REG_ADDR_W-3:0], 2'h0};
  localparam logic [REG_ADDR_W-1:0] ADDR_SENSE = {IDX_SENSE[REG_ADDR_W-3:0], 2'h0};
  localparam logic [REG_ADDR_W-1:0] ADDR_EVENT_STATUS = {IDX_EVENT_STATUS[REG_ADDR_W-3:0], 2'h0};
  localparam logic [REG_ADDR_W-1:0] ADDR_EVENT_MASK = {IDX_EVENT_MASK[REG_ADDR_W-3:0], 2'h0};

  // ****************************************************************
  // field positions
  // ****************************************************************
  localparam int BIT_EXT_IRQ0 = 6;
  localparam int BIT_GROUP2 = 5;
  localparam int BIT_GROUP1 = 4;
  localparam int BIT_GROUP0 = 3;
  localparam logic [7:0] SOURCE_BITS_MASK = 8'h78;
  localparam logic [7:0] SENSE_BITS_MASK = 8'h03;

  // pin change groups: base pin and width
  localparam int PIN_COUNT = 18;
  localparam int GROUP0_BASE = 0;
  localparam int GROUP0_W = 8;
  localparam int GROUP1_BASE = 8;
  localparam int GROUP1_W = 4;
  localparam int GROUP2_BASE = 12;
  localparam int GROUP2_W = 6;
  localparam int SAMPLED_W = PIN_COUNT + 1;
  localparam int EXT_IRQ0_SLOT = PIN_COUNT;

  // request / acknowledge slots toward the cpu
  localparam int SRC_COUNT = 4;
  localparam int SRC_EXT_IRQ0 = 0;
  localparam int SRC_GROUP0 = 1;
  localparam int SRC_GROUP1 = 2;
  localparam int SRC_GROUP2 = 3;

  // ****************************************************************
  // reset values
  // ****************************************************************
  localparam logic [7:0] RST_PC_MASK_GROUP0 = 8'h00;
  localparam logic [GROUP1_W-1:0] RST_PC_MASK_GROUP1 = 4'h0;
  localparam logic [GROUP2_W-1:0] RST_PC_MASK_GROUP2 = 6'h00;
  localparam logic [7:0] RST_IRQ_FLAGS = 8'h00;
  localparam logic [7:0] RST_IRQ_ENABLES = 8'h00;
  localparam logic [1:0] RST_SENSE = 2'h0;
  localparam logic [7:0] RST_EVENT_STATUS = 8'h00;
  localparam logic [7:0] RST_EVENT_MASK = 8'h00;

  // trigger selection for the dedicated pin
  typedef enum logic [1:0] {
    SENSE_LOW = 2'h0,
    SENSE_CHANGE = 2'h1,
    SENSE_FALL = 2'h2,
    SENSE_RISE = 2'h3
  } sense_type;

  // axi4-lite responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : ext_irq_pkg

// *** verilog/pin_event_if.sv ***
// sampled pin levels and one-cycle edge strobes
interface pin_event_if #(
  parameter int WIDTH = 19
);
  logic [WIDTH-1:0] level;
  logic [WIDTH-1:0] rise;
  logic [WIDTH-1:0] fall;

  modport source (
    output level,
    output rise,
    output fall
  );

  modport sink (
    input level,
    input rise,
    input fall
  );
endinterface : pin_event_if

// *** verilog/pin_edge_sampler.sv ***
module pin_edge_sampler
  import ext_irq_pkg::*;
#(
  parameter int WIDTH = SAMPLED_W
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // asynchronous pins
  input wire logic [WIDTH-1:0] pins,
  // sampled results
  pin_event_if.source events
);

  // ****************************************************************
  // elaboration check
  // ****************************************************************
  if (WIDTH < 1) begin : bad_width
    $error("pin_edge_sampler needs at least one pin");
  end

  // ****************************************************************
  // warm-up after reset
  // ****************************************************************
  // edges stay blocked until the sampled and previous stages hold real pin values,
  // otherwise a pin idling high would fake a rise right after reset
  logic [2:0] primed;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      primed <= 3'h0;
    end else begin
      primed <= {primed[1:0], 1'b1};
    end
  end

  // ****************************************************************
  // per-pin synchroniser and edge detector
  // ****************************************************************
  for (genvar i = 0; i < WIDTH; i++) begin : g_pin
    logic meta;
    logic sampled;
    logic previous;

    // two stages before any logic looks at the pin
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        meta <= 1'b0;
        sampled <= 1'b0;
        previous <= 1'b0;
      end else begin
        meta <= pins[i];
        sampled <= meta;
        previous <= sampled;
      end
    end

    // compare the synchronised sample with its registered predecessor
    assign events.level[i] = sampled;
    assign events.rise[i] = primed[2] & sampled & ~previous;
    assign events.fall[i] = primed[2] & ~sampled & previous;
  end

endmodule : pin_edge_sampler

// *** testbench/cpu_vector_model.sv ***
module cpu_vector_model
  import ext_irq_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // vectoring side
  input wire logic ack_en,
  input wire logic [SRC_COUNT-1:0] irq_request,
  output logic [SRC_COUNT-1:0] service_ack
);
  timeunit 1ns;
  timeprecision 1ns;

  // enter the lowest pending handler; one idle cycle after each ack, too short for the cleared flag to drop the request first
  always_ff @(posedge aclk) begin
    if (!aresetn || !ack_en || service_ack != 4'h0) begin
      service_ack <= 4'h0;
    end else begin
      service_ack <= irq_request & -irq_request;
    end
  end
endmodule : cpu_vector_model

// *** testbench/ext_irq_controller_monitor.sv ***
module ext_irq_monitor
  import ext_irq_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // register bus
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // pins and cpu side
  input wire logic [PIN_COUNT-1:0] pin_change_input,
  input wire logic global_irq_en,
  input wire logic [SRC_COUNT-1:0] service_ack,
  input wire logic [SRC_COUNT-1:0] irq_request
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  logic [PIN_COUNT-1:0] last_pins;
  logic [2:0] quiet;

  // edges since the pins last moved; an ack only clears when no change is still in flight
  always_ff @(posedge aclk) begin
    last_pins <= pin_change_input;
    if (!aresetn || pin_change_input != last_pins) begin
      quiet <= 3'h0;
    end else if (quiet != 3'h7) begin
      quiet <= quiet + 3'h1;
    end
  end

  rdata_high_zero_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
    else $error("read data above bit 7 not zero");
  request_gate_a: assert property (!$past(global_irq_en) |-> irq_request == 4'h0)
    else $error("request without global enable");
  group0_ack_a: assert property (service_ack[1] && quiet > 3'h3 |-> ##2 !irq_request[1])
    else $error("group 0 request kept after service");
  group2_ack_a: assert property (service_ack[3] && quiet > 3'h3 |-> ##2 !irq_request[3])
    else $error("group 2 request kept after service");
  read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("no read answer one cycle after address");
  write_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##[1:3] s_axi_bvalid)
    else $error("no write response");
  bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
  aw_refuse_a: assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
    else $error("second write address accepted");
endmodule : ext_irq_monitor

bind ext_irq_controller ext_irq_monitor mon_u (
  .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .pin_change_input(pin_change_input), .global_irq_en(global_irq_en),
  .service_ack(service_ack), .irq_request(irq_request)
);

// *** testbench/tb_ext_irq_controller.sv ***
module tb_ext_irq_controller
  import ext_irq_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic aclk, aresetn, ext_irq0, global_irq_en, irq, ack_en;
  logic [REG_ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
  logic [2:0] s_axi_awprot, s_axi_arprot;
  logic [31:0] s_axi_wdata, s_axi_rdata, rdata_seen;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, rresp_seen, bresp_seen;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [PIN_COUNT-1:0] pin_change_input;
  logic [SRC_COUNT-1:0] service_ack, irq_request;
  int mismatches, comparisons, cycles;
  logic [11:0] regs [7] = '{ADDR_PC_MASK_GROUP0, ADDR_PC_MASK_GROUP1, ADDR_PC_MASK_GROUP2, ADDR_SENSE,
    ADDR_IRQ_ENABLES, ADDR_IRQ_FLAGS, ADDR_EVENT_MASK};
  logic [7:0] rw_bits [7] = '{8'hFF, 8'h0F, 8'h3F, 8'h03, 8'h78, 8'h00, 8'h78};
  logic [11:0] gaddr [3] = '{ADDR_PC_MASK_GROUP0, ADDR_PC_MASK_GROUP1, ADDR_PC_MASK_GROUP2};
  logic [7:0] gmask [3] = '{8'hFE, 8'h0E, 8'h3E};
  int gbase [3] = '{GROUP0_BASE, GROUP1_BASE, GROUP2_BASE};
  int gtop [3] = '{GROUP0_BASE + GROUP0_W - 1, GROUP1_BASE + GROUP1_W - 1, GROUP2_BASE + GROUP2_W - 1};
  logic [7:0] fall_exp [4] = '{8'h00, 8'h40, 8'h40, 8'h00};
  logic [7:0] rise_exp [4] = '{8'h00, 8'h40, 8'h00, 8'h40};

  ext_irq_controller dut_u (.*);
  cpu_vector_model cpu_u (.aclk(aclk), .aresetn(aresetn), .ack_en(ack_en), .irq_request(irq_request),
    .service_ack(service_ack));

  // 50 ns clock
  initial begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end

  // hang guard, well above the few hundred cycles the tests need
  always @(posedge aclk) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      complete_run();
    end
  end

  task automatic check(input logic [33:0] seen, input logic [33:0] exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask : check

  task automatic tick(input int n);
    repeat (n) @(posedge aclk);
  endtask : tick

  // address and data offered together, each released once taken
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    logic awp = 1'b1;
    logic wp = 1'b1;
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h000000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (awp || wp) begin
      @(posedge aclk);
      awp = awp && s_axi_awready !== 1'b1;
      wp = wp && s_axi_wready !== 1'b1;
      s_axi_awvalid <= awp;
      s_axi_wvalid <= wp;
    end
    do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b1;
    do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    bresp_seen = s_axi_bresp;
  endtask : wr

  task automatic rd(input logic [11:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    rdata_seen = s_axi_rdata;
    rresp_seen = s_axi_rresp;
  endtask : rd

  task automatic rd_check(input logic [11:0] a, input logic [7:0] e, input logic [1:0] er);
    rd(a);
    check({rresp_seen, rdata_seen}, {er, 24'h000000, e});
  endtask : rd_check

  // pin moves, then time for the synchroniser and flag pipeline to settle
  task automatic toggle(input int p);
    pin_change_input[p] <= ~pin_change_input[p];
    tick(6);
  endtask : toggle

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : complete_run

  initial begin
    aresetn = 1'b0;
    {s_axi_awaddr, s_axi_araddr, s_axi_awprot, s_axi_arprot, s_axi_wdata} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    s_axi_wstrb = 4'hF;
    {ext_irq0, global_irq_en, ack_en, pin_change_input} = {1'b1, 20'h00000};
    tick(3);
    aresetn <= 1'b1;
    tick(1);
    // reset values, writable bits, reserved bits, unmapped place
    for (int i = 0; i < 7; i++) begin
      rd_check(regs[i], 8'h00, RESP_OKAY);
      wr(regs[i], 8'hFF);
      check(34'(bresp_seen), 34'(RESP_OKAY));
      rd_check(regs[i], rw_bits[i], RESP_OKAY);
    end
    rd_check(12'hFFC, 8'h00, RESP_SLVERR);
    wr(12'hFFC, 8'hFF);
    check(34'(bresp_seen), 34'(RESP_SLVERR));
    $display("register test done");
    // each group: masked pin, enabled pin, global gate, service, group disabled
    for (int g = 0; g < 3; g++) begin
      ack_en <= 1'b0;
      global_irq_en <= 1'b0;
      wr(gaddr[g], gmask[g]);
      wr(ADDR_IRQ_ENABLES, 8'h08 << g);
      toggle(gbase[g]);
      rd_check(ADDR_IRQ_FLAGS, 8'h00, RESP_OKAY);
      toggle(gtop[g]);
      rd_check(ADDR_IRQ_FLAGS, 8'h08 << g, RESP_OKAY);
      check(34'(irq_request), 34'h0);
      global_irq_en <= 1'b1;
      tick(3);
      check(34'(irq_request), 34'(4'h1 << (SRC_GROUP0 + g)));
      ack_en <= 1'b1;
      tick(4);
      rd_check(ADDR_IRQ_FLAGS, 8'h00, RESP_OKAY);
      wr(ADDR_IRQ_ENABLES, 8'h00);
      toggle(gtop[g]);
      rd_check(ADDR_IRQ_FLAGS, 8'h00, RESP_OKAY);
    end
    $display("pin change test done");
    // dedicated pin in every sense mode, flags cleared by writing one
    global_irq_en <= 1'b0;
    ack_en <= 1'b0;
    wr(ADDR_IRQ_ENABLES, 8'h40);
    for (int m = 0; m < 4; m++) begin
      wr(ADDR_SENSE, 8'(m));
      wr(ADDR_IRQ_FLAGS, 8'h40);
      ext_irq0 <= 1'b0; // held low over several instructions
      tick(6);
      rd_check(ADDR_IRQ_FLAGS, fall_exp[m], RESP_OKAY);
      global_irq_en <= 1'b1;
      tick(3);
      check(34'(irq_request), 34'(m < 3));
      global_irq_en <= 1'b0;
      wr(ADDR_IRQ_FLAGS, 8'h40);
      rd_check(ADDR_IRQ_FLAGS, 8'h00, RESP_OKAY);
      ext_irq0 <= 1'b1;
      tick(6);
      rd_check(ADDR_IRQ_FLAGS, rise_exp[m], RESP_OKAY);
    end
    $display("sense test done");
    // summary line: raise, clear by reading, then masked
    wr(ADDR_IRQ_ENABLES, 8'h08);
    wr(ADDR_PC_MASK_GROUP0, 8'hFF);
    wr(ADDR_EVENT_MASK, 8'h08);
    rd(ADDR_EVENT_STATUS);
    toggle(0);
    check(34'(irq), 34'h1);
    rd_check(ADDR_EVENT_STATUS, 8'h08, RESP_OKAY);
    rd_check(ADDR_EVENT_STATUS, 8'h00, RESP_OKAY);
    check(34'(irq), 34'h0);
    wr(ADDR_EVENT_MASK, 8'h00);
    toggle(0);
    check(34'(irq), 34'h0);
    rd_check(ADDR_EVENT_STATUS, 8'h08, RESP_OKAY);
    $display("interrupt line test done");
    complete_run();
  end
endmodule : tb_ext_irq_controller
